// file: core/pcr_device.sv
// converter end: link decoder, register bank, setpoint decode and ramp
`timescale 1ns/1ps
module pcr_device (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              rst_n,
  // shared lines
  pcr_link_if.dev                                link,
  // address straps
  input  wire logic                              node_id_strap_0,
  input  wire logic                              node_id_strap_1,
  input  wire logic                              node_id_strap_2,
  input  wire logic                              node_id_strap_3,
  input  wire logic                              node_id_strap_4,
  // converter side
  input  wire logic [7:0]                        fault_event,
  input  wire logic [7:0]                        vout_meas,
  input  wire logic [7:0]                        iout_meas,
  input  wire logic [7:0]                        temp_meas,
  output logic      [pcr_pkg::NUM_CFG-1:0][7:0]  cfg_bytes,
  output logic      [pcr_pkg::NODE_W-1:0]        node_id,
  output logic                                   output_on,
  output logic      [8:0]                        target_level,
  output logic      [8:0]                        ramp_level,
  output logic                                   power_good_out,
  output logic                                   group_fault
);
  import pcr_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_HDR, D_DATA} pcr_dev_state_t;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [8:0] sp_level(input logic [7:0] code);
    logic [8:0] c;
    c = {1'b0, code};
    if (code <= SP_SEG1_END) begin
      sp_level = SP_BASE1 + c;
    end else if (code <= SP_SEG2_END) begin
      sp_level = SP_BASE2 + ((c - {1'b0, SP_SEG1_END}) << 1);
    end else begin
      sp_level = SP_BASE3 + ((c - {1'b0, SP_SEG2_END}) << 2);
    end
  endfunction

  function automatic logic is_locked(input logic [4:0] a);
    is_locked = (a == REG_PHASE_FREQ) || (a == REG_DUTY) ||
                (a >= REG_DEN_1 && a <= REG_NUM3_HI);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0]        sd_sync;
  logic              sd_q;
  logic [1:0]        ok_sync;
  logic [4:0]        strap_s1;
  logic [4:0]        strap_s2;
  logic [1:0]        cap_cnt;
  logic              captured;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sd_sync  <= 2'h3;
      sd_q     <= 1'b1;
      ok_sync  <= 2'h3;
      strap_s1 <= 5'h1F;
      strap_s2 <= 5'h1F;
    end else begin
      sd_sync  <= {sd_sync[0], link.sd_line};
      sd_q     <= sd_sync[1];
      ok_sync  <= {ok_sync[0], link.ok_line};
      strap_s1 <= {node_id_strap_4, node_id_strap_3, node_id_strap_2,
                   node_id_strap_1, node_id_strap_0};
      strap_s2 <= strap_s1;
    end
  end

  // straps settle through the synchroniser before the one capture
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cap_cnt  <= 2'h0;
      captured <= 1'b0;
      node_id  <= 5'h00;
    end else if (!captured) begin
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_cnt == 2'h3) begin
        captured <= 1'b1;
        node_id  <= strap_s2;
      end
    end
  end

  assign group_fault = ok_sync[1];

  // ----------------------------------------
  // pulse width decode
  // ----------------------------------------
  wire       sd_now = sd_sync[1];
  wire       sd_fall = sd_q && !sd_now;
  wire       sd_rise = !sd_q && sd_now;
  logic [7:0] low_cnt;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_cnt <= 8'h00;
    end else if (sd_fall) begin
      low_cnt <= 8'h01;
    end else if (!sd_now && low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // every period opens with a low pulse; its width carries the bit
  wire bit_val = low_cnt < 8'(HALF_CYC);

  // ----------------------------------------
  // frame receiver
  // ----------------------------------------
  pcr_dev_state_t state;
  logic [4:0]     bit_cnt;
  logic [10:0]    hdr;
  logic [7:0]     data_sh;
  logic [7:0]     resp;
  logic [NUM_CFG-1:0][7:0] cfg;
  logic [7:0]     flags;
  logic [7:0]     vout_rd;
  logic [7:0]     iout_rd;
  logic [7:0]     temp_rd;

  wire [10:0] next_hdr = {hdr[9:0], bit_val};
  wire [4:0]  hdr_reg = hdr[4:0];
  wire        hdr_rd = hdr[5];
  wire        hit = hdr[10:6] == node_id;
  wire        last_data = bit_cnt == 5'(DATA_BITS - 1);
  wire        wr_fire = sd_rise && state == D_DATA && last_data && hit && !hdr_rd;
  wire [7:0]  wr_data = {data_sh[6:0], bit_val};
  wire [4:0]  rd_addr = next_hdr[4:0];

  // read mux sees the header being completed this cycle
  wire [7:0] rd_val =
    (rd_addr < 5'(NUM_CFG))  ? cfg[rd_addr] :
    (rd_addr == REG_FAULT)   ? flags :
    (rd_addr == REG_VOUT_RD) ? vout_rd :
    (rd_addr == REG_IOUT_RD) ? iout_rd :
    (rd_addr == REG_TEMP_RD) ? temp_rd : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state   <= D_IDLE;
      bit_cnt <= 5'h00;
      hdr     <= 11'h000;
      data_sh <= 8'h00;
      resp    <= 8'hFF;
    end else if (sd_rise) begin
      case (state)
        D_IDLE: begin
          bit_cnt <= 5'h00;
          if (!bit_val) begin
            state <= D_HDR;
          end
        end
        D_HDR: begin
          hdr     <= next_hdr;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == 5'(HDR_BITS - 1)) begin
            state   <= D_DATA;
            bit_cnt <= 5'h00;
            resp    <= rd_val;
          end
        end
        D_DATA: begin
          data_sh <= wr_data;
          resp    <= {resp[6:0], 1'b1};
          bit_cnt <= bit_cnt + 5'h01;
          if (last_data) begin
            state <= D_IDLE;
          end
        end
        default: begin
          state <= D_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // answer driver: stretch the manager's short pulse into a zero
  // ----------------------------------------
  logic [7:0] drive_cnt;
  wire        drive_go = sd_fall && state == D_DATA && hit && hdr_rd && !resp[7];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drive_cnt        <= 8'h00;
      link.dev_sd_oe_n <= 1'b1;
    end else if (drive_go) begin
      drive_cnt        <= 8'(LONG_CYC);
      link.dev_sd_oe_n <= 1'b0;
    end else begin
      drive_cnt        <= (drive_cnt != 8'h00) ? drive_cnt - 8'h01 : 8'h00;
      link.dev_sd_oe_n <= drive_cnt <= 8'h01;
    end
  end

  assign link.dev_sd_out = 1'b0;
  assign link.dev_ok_out = 1'b0;

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  wire [7:0] flag_clr = (wr_fire && hdr_reg == REG_FAULT) ? wr_data : 8'h00;
  wire       cfg_wr = wr_fire && hdr_reg < 5'(NUM_CFG) && !(is_locked(hdr_reg) && output_on);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg              <= CFG_DEFAULT;
      flags            <= 8'h00;
      link.dev_ok_oe_n <= 1'b1;
    end else begin
      if (cfg_wr) begin
        cfg[hdr_reg] <= wr_data;
      end
      flags            <= (flags & ~flag_clr) | fault_event;
      link.dev_ok_oe_n <= flags == 8'h00;
    end
  end

  // monitoring copies refresh each link period, writes never reach them
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vout_rd <= 8'h00;
      iout_rd <= 8'h00;
      temp_rd <= 8'h00;
    end else if (sd_fall) begin
      vout_rd <= vout_meas;
      iout_rd <= iout_meas;
      temp_rd <= temp_meas;
    end
  end

  assign cfg_bytes = cfg;
  assign output_on = cfg[REG_RUN][RUN_ON_BIT];

  // ----------------------------------------
  // setpoint and ramp
  // ----------------------------------------
  logic [TC_DIV_W-1:0] div_cnt;
  wire  [8:0]          ramp_goal = output_on ? target_level : 9'h000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      target_level   <= 9'h000;
      ramp_level     <= 9'h000;
      div_cnt        <= '0;
      power_good_out <= 1'b0;
    end else begin
      target_level   <= sp_level(cfg[REG_VSET]);
      power_good_out <= output_on && ramp_level == target_level;
      if (sd_fall) begin
        // step period is a whole number of manager clocks
        if (div_cnt >= cfg[REG_TRACK][TC_DIV_W-1:0]) begin
          div_cnt <= '0;
          if (ramp_level < ramp_goal) begin
            ramp_level <= ramp_level + 9'h001;
          end else if (ramp_level > ramp_goal) begin
            ramp_level <= ramp_level - 9'h001;
          end
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end
    end
  end
endmodule

// file: core/pcr_pkg.sv
// shared constants for the point-of-load register port and its manager
package pcr_pkg;
  // ----------------------------------------
  // link timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 2000;
  localparam int PERIOD_CYC     = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SHORT_CYC      = PERIOD_CYC / 4;
  localparam int LONG_CYC       = (PERIOD_CYC * 3) / 4;
  localparam int HALF_CYC       = PERIOD_CYC / 2;
  // ----------------------------------------
  // frame layout: start, node, read flag, register, data
  // ----------------------------------------
  localparam int NODE_W     = 5;
  localparam int HDR_BITS   = 11;
  localparam int DATA_BITS  = 8;
  localparam int FRAME_BITS = 20;
  // ----------------------------------------
  // converter register offsets
  // ----------------------------------------
  localparam logic [4:0] REG_PROT_A     = 5'h00;
  localparam logic [4:0] REG_PROT_B     = 5'h01;
  localparam logic [4:0] REG_PROT_C     = 5'h02;
  localparam logic [4:0] REG_TRACK      = 5'h03;
  localparam logic [4:0] REG_PHASE_FREQ = 5'h04;
  localparam logic [4:0] REG_ON_DELAY   = 5'h05;
  localparam logic [4:0] REG_OFF_DELAY  = 5'h06;
  localparam logic [4:0] REG_VSET       = 5'h07;
  localparam logic [4:0] REG_CUR_LIMIT  = 5'h08;
  localparam logic [4:0] REG_DUTY       = 5'h09;
  localparam logic [4:0] REG_DEN_1      = 5'h0A;
  localparam logic [4:0] REG_DEN_2      = 5'h0B;
  localparam logic [4:0] REG_DEN_3      = 5'h0C;
  localparam logic [4:0] REG_NUM0_LO    = 5'h0D;
  localparam logic [4:0] REG_NUM0_HI    = 5'h0E;
  localparam logic [4:0] REG_NUM1_LO    = 5'h0F;
  localparam logic [4:0] REG_NUM1_HI    = 5'h10;
  localparam logic [4:0] REG_NUM2_LO    = 5'h11;
  localparam logic [4:0] REG_NUM2_HI    = 5'h12;
  localparam logic [4:0] REG_NUM3_LO    = 5'h13;
  localparam logic [4:0] REG_NUM3_HI    = 5'h14;
  localparam logic [4:0] REG_RUN        = 5'h15;
  localparam logic [4:0] REG_FAULT      = 5'h16;
  localparam logic [4:0] REG_VOUT_RD    = 5'h17;
  localparam logic [4:0] REG_IOUT_RD    = 5'h18;
  localparam logic [4:0] REG_TEMP_RD    = 5'h19;
  localparam int         NUM_CFG        = 22;
  // defaults, index 21 first; setpoint 1.0 V, divider 3, duty C0
  localparam logic [NUM_CFG-1:0][7:0] CFG_DEFAULT = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hC0, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  localparam int RUN_ON_BIT = 0;
  localparam int TC_DIV_W   = 3;
  // ----------------------------------------
  // setpoint sub-ranges, level in 12.5 mV units
  // ----------------------------------------
  localparam logic [7:0] SP_SEG1_END = 8'h78;
  localparam logic [7:0] SP_SEG2_END = 8'hFA;
  localparam logic [8:0] SP_BASE1    = 9'h028;
  localparam logic [8:0] SP_BASE2    = 9'h0A0;
  localparam logic [8:0] SP_BASE3    = 9'h1A4;
  // ----------------------------------------
  // manager registers on the AXI4-Lite side
  // ----------------------------------------
  localparam logic [7:0] MGR_CTRL      = 8'h00;
  localparam logic [7:0] MGR_STAT      = 8'h04;
  localparam logic [7:0] MGR_ISTAT     = 8'h08;
  localparam logic [7:0] MGR_IMASK     = 8'h0C;
  localparam int         CTRL_NODE_LSB = 0;
  localparam int         CTRL_RD_BIT   = 5;
  localparam int         CTRL_REG_LSB  = 8;
  localparam int         CTRL_DATA_LSB = 16;
  localparam int         CTRL_GO_BIT   = 31;
  localparam int         IRQ_DONE_BIT  = 0;
  localparam int         IRQ_FAULT_BIT = 1;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// file: core/pcr_link_if.sv
// shared sync/data line and fault/status line between manager and converter
`timescale 1ns/1ps
interface pcr_link_if;
  logic mgr_sd_out;
  logic mgr_sd_oe_n;
  logic dev_sd_out;
  logic dev_sd_oe_n;
  logic dev_ok_out;
  logic dev_ok_oe_n;
  wire  sd_line;
  wire  ok_line;
  // wired-and with pull-up: any enabled low driver wins
  assign sd_line = !((!mgr_sd_oe_n && !mgr_sd_out) || (!dev_sd_oe_n && !dev_sd_out));
  assign ok_line = !(!dev_ok_oe_n && !dev_ok_out);
  modport mgr (
    input  sd_line,
    input  ok_line,
    output mgr_sd_out,
    output mgr_sd_oe_n
  );
  modport dev (
    input  sd_line,
    input  ok_line,
    output dev_sd_out,
    output dev_sd_oe_n,
    output dev_ok_out,
    output dev_ok_oe_n
  );
endinterface

// file: core/pcr_manager.sv
// manager end: AXI4-Lite command registers and line master
`timescale 1ns/1ps
module pcr_manager (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq,
  // shared lines
  pcr_link_if.mgr          link
);
  import pcr_pkg::*;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = a == MGR_CTRL || a == MGR_STAT || a == MGR_ISTAT || a == MGR_IMASK;
  endfunction

  // ----------------------------------------
  // line sampling
  // ----------------------------------------
  logic [1:0] sd_sync;
  logic [1:0] ok_sync;
  logic       ok_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sd_sync <= 2'h3;
      ok_sync <= 2'h3;
      ok_q    <= 1'b1;
    end else begin
      sd_sync <= {sd_sync[0], link.sd_line};
      ok_sync <= {ok_sync[0], link.ok_line};
      ok_q    <= ok_sync[1];
    end
  end

  // ----------------------------------------
  // AXI write path
  // ----------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [31:0] ctrl;
  logic [1:0]  istat;
  logic [1:0]  imask;
  logic        busy;
  logic [7:0]  rx_byte;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_en = do_write && w_strb_q != 4'h0;
  wire go = wr_en && aw_addr_q == MGR_CTRL && w_data_q[CTRL_GO_BIT] && !busy;
  wire [1:0] clr = (wr_en && aw_addr_q == MGR_ISTAT) ? w_data_q[1:0] : 2'h0;
  logic done_ev;
  wire fault_ev = ok_q && !ok_sync[1];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      ctrl         <= 32'h0000_0000;
      imask        <= 2'h0;
      istat        <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_en && aw_addr_q == MGR_CTRL && !busy) begin
        ctrl <= {1'b0, w_data_q[30:0]};
      end
      if (wr_en && aw_addr_q == MGR_IMASK) begin
        imask <= w_data_q[1:0];
      end
      // a new event beats a clear in the same cycle
      istat <= (istat & ~clr) | {fault_ev, done_ev};
    end
  end

  assign irq = |(istat & imask);

  // ----------------------------------------
  // AXI read path
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  wire [31:0] rd_mux =
    (s_axi_araddr == MGR_CTRL)  ? ctrl :
    (s_axi_araddr == MGR_STAT)  ? {15'h0000, ok_sync[1], rx_byte, 7'h00, busy} :
    (s_axi_araddr == MGR_ISTAT) ? {30'h0000_0000, istat} :
    (s_axi_araddr == MGR_IMASK) ? {30'h0000_0000, imask} : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // line master: free-running clock, frames ride on it
  // ----------------------------------------
  logic [7:0]            cnt;
  logic                  cur_bit;
  logic [FRAME_BITS-1:0] tx_sh;
  logic [4:0]            bit_no;
  logic                  rd_frame;
  logic [7:0]            rx_sh;

  wire       at_end = cnt == 8'(PERIOD_CYC - 1);
  wire       finish = busy && bit_no == 5'(FRAME_BITS);
  wire       next_bit = !at_end ? cur_bit : (busy && !finish) ? tx_sh[FRAME_BITS-1] : 1'b1;
  wire [7:0] next_cnt = at_end ? 8'h00 : cnt + 8'h01;
  wire [7:0] next_thr = next_bit ? 8'(SHORT_CYC) : 8'(LONG_CYC);
  wire       rd_go = w_data_q[CTRL_RD_BIT];
  wire [7:0] tx_data = rd_go ? 8'hFF : w_data_q[CTRL_DATA_LSB +: 8];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // first edge after release wraps to zero: first low pulse is full width
      cnt              <= 8'(PERIOD_CYC - 1);
      cur_bit          <= 1'b1;
      tx_sh            <= '1;
      bit_no           <= 5'h00;
      busy             <= 1'b0;
      rd_frame         <= 1'b0;
      rx_sh            <= 8'h00;
      rx_byte          <= 8'h00;
      done_ev          <= 1'b0;
      link.mgr_sd_oe_n <= 1'b1;
    end else begin
      cnt              <= next_cnt;
      cur_bit          <= next_bit;
      link.mgr_sd_oe_n <= !(next_cnt < next_thr);
      done_ev          <= 1'b0;
      if (go) begin
        busy     <= 1'b1;
        rd_frame <= rd_go;
        bit_no   <= 5'h00;
        tx_sh    <= {1'b0, w_data_q[CTRL_NODE_LSB +: NODE_W], rd_go,
                     w_data_q[CTRL_REG_LSB +: 5], tx_data};
      end else if (at_end && finish) begin
        busy    <= 1'b0;
        done_ev <= 1'b1;
        if (rd_frame) begin
          rx_byte <= rx_sh;
        end
      end else if (at_end && busy) begin
        tx_sh  <= {tx_sh[FRAME_BITS-2:0], 1'b1};
        bit_no <= bit_no + 5'h01;
      end
      // converter stretches a zero past mid-period
      if (cnt == 8'(HALF_CYC) && busy && rd_frame && bit_no > 5'(HDR_BITS + 1)) begin
        rx_sh <= {rx_sh[6:0], sd_sync[1]};
      end
    end
  end

  assign link.mgr_sd_out = 1'b0;
endmodule

// file: tb/pcr_chk.sv
// link checker for the shared sync/data and fault/status lines
`timescale 1ns/1ps
module pcr_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link signals
  input wire logic mgr_sd_out,
  input wire logic mgr_sd_oe_n,
  input wire logic dev_sd_out,
  input wire logic dev_sd_oe_n,
  input wire logic dev_ok_out,
  input wire logic dev_ok_oe_n,
  input wire logic sd_line,
  input wire logic ok_line
);
  logic mq, lq, seen;
  int   ml, ll, pc;
  wire  mfall = mq && !mgr_sd_oe_n;
  wire  mrise = !mq && mgr_sd_oe_n;
  wire  lrise = !lq && sd_line;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ------
  // low widths and period
  // ------
  always_ff @(posedge mclk) begin
    mq   <= mgr_sd_oe_n | !rst_n;
    lq   <= sd_line | !rst_n;
    ml   <= (mgr_sd_oe_n || !rst_n) ? 0 : ml + 1;
    ll   <= (sd_line || !rst_n) ? 0 : ll + 1;
    pc   <= mfall ? 1 : pc + 1;
    seen <= rst_n && (seen || mfall);
  end
  // ------
  // properties
  // ------
  a_rel_reset: assert property (
    $rose(rst_n) |-> mgr_sd_oe_n && dev_sd_oe_n && dev_ok_oe_n)
    else $error("line driven at reset release");
  a_clk_start: assert property ($rose(rst_n) |-> ##[1:3] !mgr_sd_oe_n)
    else $error("line clock did not start");
  a_mgr_low: assert property (!mgr_sd_oe_n |-> !mgr_sd_out)
    else $error("manager drives line high");
  a_dev_low: assert property (!dev_sd_oe_n |-> !dev_sd_out)
    else $error("converter drives line high");
  a_ok_low: assert property (!dev_ok_oe_n |-> !dev_ok_out)
    else $error("fault line driven high");
  a_dev_join: assert property ($fell(dev_sd_oe_n) |-> !mgr_sd_oe_n)
    else $error("stretch outside a low pulse");
  a_mgr_width: assert property (mrise |-> ml == 50 || ml == 150)
    else $error("manager low width wrong");
  a_line_width: assert property (lrise |-> ll inside {[49:51], [148:156]})
    else $error("line low width wrong");
  a_period_len: assert property (mfall && seen |-> pc == 200)
    else $error("line period wrong");
  c_stretch: cover property ($fell(dev_sd_oe_n));
  c_fault: cover property ($fell(ok_line));
  c_zero: cover property (mrise && ml == 150);
endmodule

// file: tb/tb_pol_config_register_port.sv
// self-checking bench: manager and converter joined on one link
`timescale 1ns/1ps
module tb_pol_config_register_port;
  import pcr_pkg::*;
  logic                         mclk, rst_n, awv, wv, bry, arv, rry;
  logic [7:0]                   awa, ara, fev, vm, v;
  logic [4:0]                   strap;
  logic [31:0]                  wd, rdat;
  logic [1:0]                   rsp;
  wire logic                    awr, wr, bv, arr, rv, irq, oo, pg, gf;
  wire logic [31:0]             rd;
  wire logic [1:0]              br, rr;
  wire logic [NUM_CFG-1:0][7:0] cfg;
  wire logic [8:0]              tl, rl;
  wire logic [4:0]              nid;
  int error_cnt, n_tests, cyc, seed, mdl[NUM_CFG];
  int cs[5] = '{0, 120, 121, 250, 255};
  pcr_link_if lnk ();
  pcr_device u_pcr_device (.mclk(mclk), .rst_n(rst_n), .link(lnk.dev),
    .node_id_strap_0(strap[0]), .node_id_strap_1(strap[1]), .node_id_strap_2(strap[2]),
    .node_id_strap_3(strap[3]), .node_id_strap_4(strap[4]), .fault_event(fev),
    .vout_meas(vm), .iout_meas(8'h00), .temp_meas(8'h00), .cfg_bytes(cfg), .node_id(nid),
    .output_on(oo), .target_level(tl), .ramp_level(rl), .power_good_out(pg), .group_fault(gf));
  pcr_manager u_pcr_manager (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .irq(irq), .link(lnk.mgr));
  pcr_chk u_chk (.mclk(mclk), .rst_n(rst_n), .mgr_sd_out(lnk.mgr_sd_out),
    .mgr_sd_oe_n(lnk.mgr_sd_oe_n), .dev_sd_out(lnk.dev_sd_out),
    .dev_sd_oe_n(lnk.dev_sd_oe_n), .dev_ok_out(lnk.dev_ok_out),
    .dev_ok_oe_n(lnk.dev_ok_oe_n), .sd_line(lnk.sd_line), .ok_line(lnk.ok_line));
  // ------
  // helpers and bus tasks
  // ------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic int sp(int c);
    if (c <= 120) return 40 + c;
    if (c <= 250) return 160 + 2 * (c - 120);
    return 420 + 4 * (c - 250);
  endfunction
  task automatic wr32(logic [7:0] a, logic [31:0] d);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    // bready and rready stay high: a lowered ready would be raised again in one step
    do begin
      @(posedge mclk);
      if (awr && awv) awv <= 1'b0;
      if (wr && wv) wv <= 1'b0;
    end while (!bv);
    rsp = br;
  endtask
  task automatic rd32(logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge mclk);
      if (arr && arv) arv <= 1'b0;
    end while (!rv);
    rdat = rd;
    rsp  = rr;
  endtask
  // one frame, then the model follows and every stored byte is compared
  task automatic frame(logic [4:0] n, logic r, logic [4:0] g, logic [7:0] d);
    logic lk;
    wr32(MGR_CTRL, {1'b1, 7'h00, d, 3'h0, g, 2'h0, r, n});
    do rd32(MGR_STAT); while (rdat[0] !== 1'b0);
    lk = (g == 4 || (g >= 9 && g <= 20)) && mdl[21][0];
    if (!r && n == strap && g <= 5'h15 && !lk) mdl[g] = d;
    foreach (mdl[i]) chk("cfg", mdl[i], cfg[i]);
  endtask
  task automatic rst();
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    foreach (mdl[i]) mdl[i] = CFG_DEFAULT[i];
    foreach (mdl[i]) chk("dflt", mdl[i], cfg[i]);
    chk("node", strap, nid);
    chk("level", sp(mdl[7]), tl);
  endtask
  // ------
  // clock, hang guard, sequence
  // ------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // a frame takes at most about 4200 cycles; fifteen of them fit well below this
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    seed  = 88052;
    strap = 5'($random(seed));
    vm    = 8'($random(seed));
    {awv, wv, arv} = '0;
    {bry, rry} = 2'h3;
    {awa, ara, fev, wd} = '0;
    rst();
    foreach (cs[i]) begin
      frame(strap, 1'b0, REG_VSET, 8'(cs[i]));
      chk("level", sp(cs[i]), tl);
    end
    frame(strap ^ 5'h01, 1'b0, REG_CUR_LIMIT, 8'h5A);
    frame(strap, 1'b0, REG_RUN, 8'h01);
    chk("on", 1, oo);
    // msb clear, lsb set: never equal to the defaults it overwrites
    v = {1'b0, 7'($random(seed))} | 8'h01;
    frame(strap, 1'b0, REG_DUTY, v);
    frame(strap, 1'b0, REG_NUM0_HI, v);
    frame(strap, 1'b0, REG_CUR_LIMIT, v);
    chk("ramp", 1, rl != 9'h000 && rl < tl && !pg);
    frame(strap, 1'b1, REG_DUTY, 8'h00);
    chk("rdback", mdl[9], rdat[15:8]);
    frame(strap, 1'b0, REG_RUN, 8'h00);
    frame(strap, 1'b0, REG_NUM0_HI, v);
    frame(strap, 1'b1, REG_VOUT_RD, 8'h00);
    chk("vout", vm, rdat[15:8]);
    wr32(MGR_IMASK, 32'h2);
    fev <= 8'h04;
    @(posedge mclk);
    fev <= 8'h00;
    repeat (8) @(posedge mclk);
    chk("irq", 1, irq);
    chk("grp", 0, gf);
    wr32(MGR_IMASK, 32'h0);
    chk("irq", 0, irq);
    frame(strap, 1'b0, REG_FAULT, 8'hFF);
    chk("okline", 1, rdat[16]);
    chk("grp", 1, gf);
    wr32(MGR_IMASK, 32'h2);
    chk("irq", 1, irq);
    wr32(MGR_ISTAT, 32'h2);
    chk("irq", 0, irq);
    wr32(MGR_IMASK, 32'h1);
    chk("done", 1, irq);
    wr32(MGR_ISTAT, 32'h1);
    chk("done", 0, irq);
    wr32(8'h40, 32'h0);
    chk("bresp", RESP_SLVERR, rsp);
    rd32(8'h40);
    chk("rresp", RESP_SLVERR, rsp);
    rst();
    report_and_stop();
  end
endmodule
